// *** core/cib_pkg.sv ***
package cib_pkg;
  // Instruction kinds handled by the sequencer
  typedef enum logic [2:0] {
    CIB_WAIT, CIB_RTI, CIB_SWI, CIB_BRANCH, CIB_BSR, CIB_TEST
  } cib_op_t;

  // Cycle counts per instruction
  localparam logic [3:0] CYC_WAIT = 4'h9;
  localparam logic [3:0] CYC_RTI = 4'hA;
  localparam logic [3:0] CYC_SWI = 4'hC;
  localparam logic [3:0] CYC_BRANCH = 4'h4;
  localparam logic [3:0] CYC_BSR = 4'h8;
  localparam logic [3:0] CYC_TEST = 4'h6;
  // Cycle in which the test instruction would write back
  localparam logic [3:0] TEST_WB_CYC = 4'h6;
  // Software interrupt vector
  localparam logic [15:0] SWI_VEC_HI = 16'hFFFA;
  localparam logic [15:0] SWI_VEC_LO = 16'hFFFB;
  localparam logic [15:0] RESET_SP = 16'h00FF;
endpackage

// *** core/cib_stack_addr.sv ***
`timescale 1ns/100ps
// Stack address for a given cycle: base minus or plus an unsigned step, chosen by down
module cib_stack_addr (
  input wire logic [15:0] base,
  input wire logic [3:0] step,
  input wire logic down,
  output logic [15:0] addr
);
  // Descending for pushes, ascending for pulls
  always_comb begin
    if (down) begin
      addr = base - {12'h000, step};
    end else begin
      addr = base + {12'h000, step};
    end
  end
endmodule

// *** core/cib_seq.sv ***
`timescale 1ns/100ps
// Behaviour
// RULE_01: Wait: 9 cycles, push seven bytes descending
// RULE_02: Waiting: bus available high, bus floated
// RULE_03: Return: dummy fetch, cycle 3 unqualified read
// RULE_04: Return cycles 4-8 pull CC,B,A,XH,XL
// RULE_05: Return is 10 cycles, pulls PC last
// RULE_06: Software interrupt 12 cycles, vector FFFA/FFFB
// RULE_07: Branch-to-subroutine 8 cycles, pushes return address
// RULE_08: Test instruction suppresses write-back qualifier
// RULE_09: Relative branch four cycles, two unqualified
// RULE_10: Memory ignores cycles with qualifier low
module cib_seq (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire cib_pkg::cib_op_t op,
  input wire logic [15:0] opcode_addr,
  input wire logic [15:0] operand_addr,
  input wire logic branch_taken,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] index_reg,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [7:0] cond_codes,
  input wire logic irq_wake,
  input wire logic [7:0] data_in,
  output logic busy,
  output logic done,
  output logic [15:0] addr_out,
  output logic addr_oe,
  output logic valid_mem_addr,
  output logic read_not_write,
  output logic rw_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic bus_available,
  output logic [7:0] pulled_byte,
  output logic pulled_valid,
  output logic [15:0] new_pc
);
  import cib_pkg::*;

  typedef enum logic [1:0] {CIB_IDLE, CIB_RUN, CIB_HALT} cib_state_t;

  cib_state_t state;
  cib_op_t cur_op;
  logic [3:0] cyc;
  logic [3:0] last_cyc;
  logic [15:0] pc_base;
  logic [15:0] sp_base;
  logic [15:0] target;
  logic [7:0] offset;
  logic taken;
  logic [15:0] ret_addr;
  logic [15:0] sp_addr;
  logic [3:0] sp_step;
  logic sp_down;
  logic [15:0] next_addr;
  logic last_shown;
  logic next_vma;
  logic next_rnw;
  logic [7:0] next_data;

  cib_stack_addr u_sp (
    .base(sp_base),
    .step(sp_step),
    .down(sp_down),
    .addr(sp_addr)
  );

  // Length of the running instruction
  always_comb begin
    unique case (cur_op)
      CIB_WAIT: last_cyc = CYC_WAIT;
      CIB_RTI: last_cyc = CYC_RTI;
      CIB_SWI: last_cyc = CYC_SWI;
      CIB_BRANCH: last_cyc = CYC_BRANCH;
      CIB_BSR: last_cyc = CYC_BSR;
      default: last_cyc = CYC_TEST;
    endcase
  end

  // Return address follows the instruction: two bytes for branches, one for inherent ones
  assign ret_addr = pc_base + ((cur_op == CIB_BRANCH || cur_op == CIB_BSR) ? 16'h0002 : 16'h0001);
  assign target = ret_addr + {{8{offset[7]}}, offset};

  // Stack step per cycle; pushes count down from cycle 3 (cycle 4 for BSR), pulls up
  always_comb begin
    sp_down = (cur_op != CIB_RTI);
    if (cur_op == CIB_BSR) begin
      sp_step = cyc - 4'h4;
    end else if (cyc >= 4'h3) begin
      sp_step = cyc - 4'h3;
    end else begin
      sp_step = 4'h0;
    end
  end

  // Per-cycle bus plan
  always_comb begin
    next_addr = pc_base;
    next_vma = 1'b1;
    next_rnw = 1'b1;
    next_data = 8'h00;
    if (cyc == 4'h2) begin
      next_addr = pc_base + 16'h0001;
    end
    unique case (cur_op)
      CIB_WAIT, CIB_SWI: begin
        if (cyc >= 4'h3 && cyc <= 4'h9) begin
          next_addr = sp_addr; // RULE_01
          next_rnw = 1'b0;
          unique case (cyc)
            4'h3: next_data = ret_addr[7:0];
            4'h4: next_data = ret_addr[15:8];
            4'h5: next_data = index_reg[7:0];
            4'h6: next_data = index_reg[15:8];
            4'h7: next_data = acc_a;
            4'h8: next_data = acc_b;
            default: next_data = cond_codes;
          endcase
        end
        if (cyc == 4'hA) begin
          next_addr = sp_addr;
          next_vma = 1'b0; // RULE_06
        end
        if (cyc == 4'hB) begin
          next_addr = SWI_VEC_HI; // RULE_06
        end
        if (cyc == 4'hC) begin
          next_addr = SWI_VEC_LO; // RULE_06
        end
      end
      CIB_RTI: begin
        if (cyc >= 4'h3) begin
          next_addr = sp_addr; // RULE_04
        end
        if (cyc == 4'h3) begin
          next_vma = 1'b0; // RULE_03
        end
      end
      CIB_BRANCH: begin
        if (cyc == 4'h3) begin
          next_addr = ret_addr; // RULE_09
          next_vma = 1'b0;
        end
        if (cyc == 4'h4) begin
          next_addr = taken ? target : ret_addr; // RULE_09
          next_vma = 1'b0;
        end
      end
      CIB_BSR: begin
        if (cyc == 4'h3 || cyc == 4'h7) begin
          next_addr = ret_addr; // RULE_07
          next_vma = 1'b0;
        end
        if (cyc == 4'h4 || cyc == 4'h5) begin
          next_addr = sp_addr; // RULE_07
          next_rnw = 1'b0;
          next_data = (cyc == 4'h4) ? ret_addr[7:0] : ret_addr[15:8];
        end
        if (cyc == 4'h6) begin
          next_addr = sp_addr;
          next_vma = 1'b0;
        end
        if (cyc == 4'h8) begin
          next_addr = target;
          next_vma = 1'b0;
        end
      end
      default: begin
        // Test reads its operand but never writes it back
        if (cyc >= 4'h3) begin
          next_addr = operand_addr;
        end
        if (cyc == TEST_WB_CYC || cyc == 4'h4) begin
          next_vma = 1'b0; // RULE_08
        end
      end
    endcase
  end

  // Sequencer state and cycle counter
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= CIB_IDLE;
      cyc <= 4'h0;
    end else begin
      unique case (state)
        CIB_IDLE: begin
          if (start) begin
            state <= CIB_RUN;
            cyc <= 4'h1;
          end
        end
        CIB_RUN: begin
          if (cyc == last_cyc) begin
            cyc <= 4'h0;
            state <= (cur_op == CIB_WAIT) ? CIB_HALT : CIB_IDLE; // RULE_02
          end else begin
            cyc <= cyc + 4'h1;
          end
        end
        CIB_HALT: begin
          // Wake-up handling lives outside; this only releases the bus
          if (irq_wake) begin
            state <= CIB_IDLE;
          end
        end
      endcase
    end
  end

  // Instruction context captured at start
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_op <= CIB_TEST;
      pc_base <= 16'h0000;
      sp_base <= RESET_SP;
      offset <= 8'h00;
      taken <= 1'b0;
    end else begin
      if (state == CIB_IDLE && start) begin
        cur_op <= op;
        pc_base <= opcode_addr;
        sp_base <= stack_ptr;
        taken <= branch_taken || op == CIB_BSR;
      end
      // The bus lags the counter, so the offset byte is on data_in at count 3
      if (state == CIB_RUN && cyc == 4'h3 && (cur_op == CIB_BRANCH || cur_op == CIB_BSR)) begin
        offset <= data_in;
      end
    end
  end

  // Registered bus drive; floats while idle or halted
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_out <= 16'h0000;
      addr_oe <= 1'b0;
      valid_mem_addr <= 1'b0;
      read_not_write <= 1'b1;
      rw_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      bus_available <= 1'b0;
    end else begin
      if (state == CIB_RUN) begin
        addr_out <= next_addr;
        addr_oe <= 1'b1;
        valid_mem_addr <= next_vma;
        read_not_write <= next_rnw;
        rw_oe <= 1'b1;
        data_out <= next_data;
        data_oe <= ~next_rnw;
      end else begin
        addr_oe <= 1'b0; // RULE_02
        valid_mem_addr <= 1'b0; // RULE_02
        rw_oe <= 1'b0;
        data_oe <= 1'b0;
      end
      bus_available <= (state == CIB_RUN && cyc == last_cyc && cur_op == CIB_WAIT) ||
        (state == CIB_HALT && !irq_wake); // RULE_02
    end
  end

  // Pulled bytes and the loaded program counter; each byte is taken one count
  // after its cycle issues, since the registered bus trails the counter
  always_ff @(posedge clk) begin
    if (reset) begin
      pulled_byte <= 8'h00;
      pulled_valid <= 1'b0;
      new_pc <= 16'h0000;
      last_shown <= 1'b0;
    end else begin
      pulled_valid <= 1'b0;
      last_shown <= done;
      if (state == CIB_RUN && cur_op == CIB_RTI && cyc >= 4'h5 && cyc <= 4'h9) begin
        pulled_byte <= data_in; // RULE_04
        pulled_valid <= 1'b1;
      end
      if (state == CIB_RUN && (cur_op == CIB_RTI || cur_op == CIB_SWI)) begin
        if (cyc == last_cyc) begin
          new_pc[15:8] <= data_in; // RULE_05
        end
      end
      // Low byte sits on the bus in the idle clock after the count ends
      if (last_shown && (cur_op == CIB_RTI || cur_op == CIB_SWI)) begin
        new_pc[7:0] <= data_in;
      end
      if (state == CIB_RUN && cur_op == CIB_BSR && cyc == 4'h8) begin
        new_pc <= target;
      end
    end
  end

  assign busy = (state != CIB_IDLE);
  assign done = (state == CIB_RUN && cyc == last_cyc);

  // Wait instruction runs exactly nine cycles
  sequence wait_run_s;
    (state == CIB_RUN && cyc == 4'h1 && cur_op == CIB_WAIT);
  endsequence
  wait_len_a: assert property (@(posedge clk) disable iff (reset)
    wait_run_s |-> ##8 done ##1 (state == CIB_HALT)) else $error("wait length wrong"); // RULE_01
  halt_float_a: assert property (@(posedge clk) disable iff (reset)
    $past(state == CIB_HALT) && state == CIB_HALT |-> bus_available && !valid_mem_addr
    && !addr_oe && !data_oe && !rw_oe) else $error("bus not floated in halt"); // RULE_02
  rti_dummy_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_RTI && cyc == 4'h3 |=> !valid_mem_addr
    && read_not_write && addr_out == sp_base) else $error("return cycle 3 wrong"); // RULE_03
  rti_pull_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_RTI && cyc == 4'h4 |=> valid_mem_addr
    && addr_out == sp_base + 16'h0001 ##4 addr_out == sp_base + 16'h0005)
    else $error("return pull order wrong"); // RULE_04
  rti_len_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_RTI && cyc == 4'h1 |-> ##9 done)
    else $error("return length wrong"); // RULE_05
  swi_vec_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_SWI && cyc == 4'hB |=> addr_out == SWI_VEC_HI
    ##1 addr_out == SWI_VEC_LO) else $error("vector fetch wrong"); // RULE_06
  bsr_push_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_BSR && cyc == 4'h4 |=> !read_not_write
    && addr_out == sp_base ##1 addr_out == sp_base - 16'h0001 ##1 !valid_mem_addr)
    else $error("subroutine push wrong"); // RULE_07
  test_nowrite_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_TEST |=> read_not_write)
    else $error("test wrote memory"); // RULE_08
  branch_len_a: assert property (@(posedge clk) disable iff (reset)
    state == CIB_RUN && cur_op == CIB_BRANCH && cyc == 4'h3 |=> !valid_mem_addr
    ##1 !valid_mem_addr && done == 1'b0) else $error("branch cycles wrong"); // RULE_09
endmodule

// *** bench/cib_mem_model.sv ***
`timescale 1ns/100ps
// Byte memory on the far side of the system bus
module cib_mem_model (
  input wire logic clk,
  input wire logic [15:0] addr_out,
  input wire logic valid_mem_addr,
  input wire logic read_not_write,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [7:0] data_in,
  output int wr_count
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h5A;
  initial wr_count = 0;
  // Only a qualified write touches storage; the bench preloads mem directly
  always @(posedge clk) begin
    last <= data_in;
    if (valid_mem_addr && !read_not_write && data_oe) begin
      mem[addr_out] <= data_out;
      wr_count <= wr_count + 1;
    end
  end
  // Unqualified cycles read back a toggling pattern so stale data never passes
  always_comb begin
    if (valid_mem_addr && read_not_write) data_in = mem[addr_out];
    else data_in = ~last;
  end
endmodule

// *** bench/test_cpu_interrupt_branch_bus_cycles.sv ***
`timescale 1ns/100ps
module test_cpu_interrupt_branch_bus_cycles;
  import cib_pkg::*;
  logic clk, reset, start, branch_taken, irq_wake, busy, done, addr_oe, valid_mem_addr;
  logic read_not_write, rw_oe, data_oe, bus_available, pulled_valid;
  cib_op_t op;
  logic [15:0] opcode_addr, operand_addr, stack_ptr, index_reg, addr_out, new_pc, tgt;
  logic [7:0] acc_a, acc_b, cond_codes, data_in, data_out, pulled_byte;
  int n_errors, tests_run, cycles, wr_count;

  cib_seq cib_seq_inst (.clk, .reset, .start, .op, .opcode_addr, .operand_addr,
    .branch_taken, .stack_ptr, .index_reg, .acc_a, .acc_b, .cond_codes, .irq_wake,
    .data_in, .busy, .done, .addr_out, .addr_oe, .valid_mem_addr, .read_not_write,
    .rw_oe, .data_out, .data_oe, .bus_available, .pulled_byte, .pulled_valid, .new_pc);
  cib_mem_model mem_inst (.clk, .addr_out, .valid_mem_addr, .read_not_write,
    .data_out, .data_oe, .data_in, .wr_count);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic results();
    $display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A hang costs a mismatch and closes the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected {vma, rw, write data, address} of bus cycle n
  function automatic logic [25:0] exp_bus(input cib_op_t k, input int n);
    logic [15:0] ra;
    logic [7:0] push [7];
    ra = opcode_addr + ((k == CIB_BSR) ? 16'h0002 : 16'h0001);
    push = '{ra[7:0], ra[15:8], index_reg[7:0], index_reg[15:8], acc_a, acc_b, cond_codes};
    if (n <= 2) return {2'b11, 8'h00, opcode_addr + 16'(n - 1)};
    case (k)
      CIB_WAIT, CIB_SWI: begin
        if (n <= 9) return {2'b10, push[n-3], stack_ptr - 16'(n - 3)};
        if (n == 10) return {2'b01, 8'h00, stack_ptr - 16'h0007};
        return {2'b11, 8'h00, (n == 11) ? SWI_VEC_HI : SWI_VEC_LO};
      end
      CIB_RTI: return {n > 3, 1'b1, 8'h00, stack_ptr + 16'(n - 3)};
      CIB_BSR: case (n)
        3, 7: return {2'b01, 8'h00, ra};
        4, 5: return {2'b10, push[n-4], stack_ptr - 16'(n - 4)};
        6: return {2'b01, 8'h00, stack_ptr - 16'h0002};
        default: return {2'b01, 8'h00, tgt};
      endcase
      default: return {2'b01, 8'h00, (n == 3 || !branch_taken) ? opcode_addr + 16'h0002 : tgt};
    endcase
  endfunction

  // Random operands; the opcode byte differs from the offset so an early capture shows
  task automatic setup(input logic [7:0] off);
    opcode_addr = {4'h2, 12'($urandom)};
    stack_ptr = {4'h8, 12'($urandom)};
    operand_addr = {4'h4, 12'($urandom)};
    index_reg = 16'($urandom);
    {acc_a, acc_b, cond_codes} = 24'($urandom);
    branch_taken = 1'($urandom);
    mem_inst.mem[opcode_addr] = ~off;
    mem_inst.mem[opcode_addr + 16'h0001] = off;
    tgt = opcode_addr + 16'h0002 + {{8{off[7]}}, off};
  endtask

  task automatic run(input cib_op_t k);
    logic [25:0] e;
    logic [3:0] nc;
    int w0;
    nc = k == CIB_WAIT ? CYC_WAIT : k == CIB_RTI ? CYC_RTI : k == CIB_SWI ? CYC_SWI :
         k == CIB_BRANCH ? CYC_BRANCH : k == CIB_BSR ? CYC_BSR : CYC_TEST;
    // Known bytes above the stack pointer for the return pulls
    for (int i = 1; i < 8; i++) mem_inst.mem[stack_ptr + 16'(i)] = 8'($urandom);
    @(posedge clk); #1;
    op = k;
    start = 1'b1;
    w0 = wr_count;
    @(posedge clk); #1;
    start = 1'b0;
    for (int n = 1; n <= nc; n++) begin
      @(posedge clk); #1;
      start = (n == 3 && nc > 6);
      e = exp_bus(k, n);
      cmp(16'(pulled_valid), 16'(k == CIB_RTI && n >= 5 && n <= 9));
      if (k == CIB_RTI && n >= 5 && n <= 9)
        cmp(16'(pulled_byte), 16'(mem_inst.mem[stack_ptr + 16'(n - 4)]));
      if (n < nc) cmp(16'(done), 16'(n + 1 == nc));
      if (k == CIB_TEST) begin
        if (n == 4 || n == 6) cmp(16'(valid_mem_addr), 16'h0000);
        cmp(16'(read_not_write), 16'h0001);
      end else begin
        cmp(addr_out, e[15:0]);
        cmp({valid_mem_addr, read_not_write}, 16'(e[25:24]));
        if (!e[24]) cmp({data_oe, data_out}, {1'b1, e[23:16]});
      end
    end
    // The last bus cycle is committed one clock after the count ends
    @(posedge clk); #1;
    if (k == CIB_RTI || k == CIB_SWI || k == CIB_BSR)
      cmp(new_pc, (k == CIB_BSR) ? tgt : (k == CIB_SWI) ?
        {mem_inst.mem[SWI_VEC_HI], mem_inst.mem[SWI_VEC_LO]} :
        {mem_inst.mem[stack_ptr + 16'h0006], mem_inst.mem[stack_ptr + 16'h0007]});
    cmp(16'(wr_count - w0), (k == CIB_WAIT || k == CIB_SWI) ? 16'h0007 :
        (k == CIB_BSR) ? 16'h0002 : 16'h0000);
    if (k == CIB_WAIT) begin
      repeat (2) @(posedge clk);
      #1;
      cmp({bus_available, addr_oe, valid_mem_addr, rw_oe, data_oe}, 16'h0010);
      irq_wake = 1'b1;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
      #1;
      irq_wake = 1'b0;
      cmp(16'(busy), 16'h0000);
    end
  endtask

  initial begin
    reset = 1'b1;
    start = 1'b0;
    irq_wake = 1'b0;
    op = CIB_WAIT;
    void'($urandom(85));
    setup(8'h00);
    mem_inst.mem[SWI_VEC_HI] = 8'($urandom);
    mem_inst.mem[SWI_VEC_LO] = 8'($urandom);
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    // Edge offsets and a stack that wraps below zero come first
    for (int r = 0; r < 8; r++)
      for (int k = 0; k < 6; k++) begin
        setup(r == 0 ? 8'h7F : r == 1 ? 8'h80 : 8'($urandom));
        if (r == 0) stack_ptr = 16'h0002;
        run(cib_op_t'(k));
      end
    results();
  end
endmodule
